// >>> verilog/timer_count_map.vh
`ifndef TIMER_COUNT_MAP_VH
`define TIMER_COUNT_MAP_VH
// ****************************************
// register byte addresses on apb
// ****************************************
`define ADDR_CONTROL 12'h000
`define ADDR_COUNT_LOW 12'h004
`define ADDR_COUNT_HIGH 12'h008
`define ADDR_FLAGS 12'h00c
// ****************************************
// control field positions
// ****************************************
`define BIT_WIDE_ACCESS 7
`define BIT_SEL_HI 6
`define BIT_PRESCALE_HI 5
`define BIT_PRESCALE_LO 4
`define BIT_SEL_LO 3
`define BIT_SYNC_DISABLE 2
`define BIT_CLOCK_SOURCE 1
`define BIT_RUN 0
// flags register fields
`define BIT_OVERFLOW_FLAG 0
`define BIT_OVERFLOW_IRQ_EN 1
// ****************************************
// reset values and timing counts
// ****************************************
`define CONTROL_RESET 8'h00
`define COUNT_RESET 16'h0000
`define INSTR_CLOCK_DIV 2'h3
`define PRESCALE_DIV2 2'h1
`define PRESCALE_DIV4 2'h2
`define PRESCALE_DIV8 2'h3
`endif

// >>> verilog/edge_qualifier.v
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// external edge qualifier
// ****************************************
module edge_qualifier (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire sync_disable,
    input wire pin_in,
    // result
    output wire rise_pulse
);
    reg meta_q;
    reg sync_q;
    reg prev_q;
    reg armed_q;
    wire level;

    // two-stage synchroniser, first stage read only by the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    // bypass the synchroniser when disabled
    assign level = sync_disable ? pin_in : sync_q; // RULE_07

    // arm on a falling edge, count rising edges after
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            prev_q <= level;
            if (prev_q && !level) begin
                armed_q <= 1'b1; // RULE_09
            end
        end
    end

    assign rise_pulse = armed_q && level && !prev_q; // RULE_09
endmodule // edge_qualifier
`default_nettype wire

// >>> verilog/sixteen_bit_timer_counter.v
// Contract
// RULE_01 - 16-bit count as two byte registers
// RULE_02 - compare trigger clears the whole count
// RULE_03 - bit 7 picks buffered 16-bit access
// RULE_04 - bits 6,3 pick compare time base
// RULE_05 - bits 5-4 prescale, code 10 divides four
// RULE_06 - 11 divides eight, 01 two, 00 one
// RULE_07 - bit 2 set skips external synchroniser
// RULE_08 - internal source ignores sync bit
// RULE_09 - bit 1 external edges, else pclk/4
// RULE_10 - bit 0 runs, clear holds count
// RULE_11 - count wraps, overflow flag latched, irq
// RULE_12 - low read snaps high, low write loads
// RULE_13 - of writes, only a low byte write clears prescaler; a selected compare trigger also clears it
// RULE_14 - write beats trigger, trigger never flags
`timescale 1ns/10ps
`default_nettype none
`include "timer_count_map.vh"
module sixteen_bit_timer_counter (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // external count input
    input wire external_count_pin,
    // compare unit special event triggers
    input wire compare_trigger_lo,
    input wire compare_trigger_hi,
    // compare time base selection and interrupt
    output wire compare_lo_uses_this,
    output wire compare_hi_uses_this,
    output wire overflow_irq
);
    // ****************************************
    // registers
    // ****************************************
    reg [7:0] control_q;
    reg [15:0] count_q;
    reg [15:0] count_d;
    reg [7:0] high_buffer_q;
    reg [2:0] prescale_q;
    reg [2:0] prescale_d;
    reg [1:0] instr_div_q;
    reg overflow_flag_q;
    reg overflow_irq_enable_q;
    reg tick;
    reg advance;
    reg wrap;
    wire ext_rise;
    wire wr;
    wire rd;
    wire mapped;
    wire wr_low;
    wire wr_high;
    wire rd_low;
    wire wide_access_enable;
    wire [1:0] input_prescale_sel;
    wire ext_sync_disable;
    wire clock_source_sel;
    wire count_run;
    wire trigger;

    // control fields
    assign wide_access_enable = control_q[`BIT_WIDE_ACCESS];
    assign input_prescale_sel =
        control_q[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO];
    assign ext_sync_disable = control_q[`BIT_SYNC_DISABLE];
    assign clock_source_sel = control_q[`BIT_CLOCK_SOURCE];
    assign count_run = control_q[`BIT_RUN];

    // ****************************************
    // apb decode
    // ****************************************
    // zero wait state slave, error on unmapped address
    assign pready = 1'b1;
    assign mapped = (paddr == `ADDR_CONTROL) ||
        (paddr == `ADDR_COUNT_LOW) || (paddr == `ADDR_COUNT_HIGH) ||
        (paddr == `ADDR_FLAGS);
    assign pslverr = psel && penable && !mapped;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign rd = psel && penable && !pwrite;
    assign wr_low = wr && (paddr == `ADDR_COUNT_LOW);
    assign wr_high = wr && (paddr == `ADDR_COUNT_HIGH);
    assign rd_low = rd && (paddr == `ADDR_COUNT_LOW);

    // time base selection for the two compare units
    assign compare_lo_uses_this =
        control_q[`BIT_SEL_HI] | control_q[`BIT_SEL_LO]; // RULE_04
    assign compare_hi_uses_this = control_q[`BIT_SEL_HI]; // RULE_04

    // a trigger counts only from a unit that selected this timer
    assign trigger = (compare_trigger_lo && compare_lo_uses_this) ||
        (compare_trigger_hi && compare_hi_uses_this); // RULE_02

    assign overflow_irq = overflow_flag_q && overflow_irq_enable_q; // RULE_11

    // ****************************************
    // external input qualifier
    // ****************************************
    edge_qualifier u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .sync_disable(ext_sync_disable),
        .pin_in(external_count_pin),
        .rise_pulse(ext_rise)
    );

    // instruction clock divider, free running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_div_q <= 2'h0;
        end else begin
            instr_div_q <= instr_div_q + 2'h1;
        end
    end

    // prescale terminal check
    function prescale_done;
        input [1:0] sel;
        input [2:0] cnt;
        begin
            case (sel)
                `PRESCALE_DIV2: prescale_done = (cnt[0] == 1'b1);
                `PRESCALE_DIV4: prescale_done = (cnt[1:0] == 2'h3); // RULE_05
                `PRESCALE_DIV8: prescale_done = (cnt == 3'h7); // RULE_06
                default: prescale_done = 1'b1; // RULE_06
            endcase
        end
    endfunction

    // ****************************************
    // count next state
    // ****************************************
    always @* begin
        // internal source ignores the sync bit
        tick = clock_source_sel ? ext_rise :
            (instr_div_q == `INSTR_CLOCK_DIV); // RULE_08 RULE_09
        advance = 1'b0;
        wrap = 1'b0;
        prescale_d = prescale_q;
        count_d = count_q;
        if (count_run && tick) begin // RULE_10
            if (prescale_done(input_prescale_sel, prescale_q)) begin
                prescale_d = 3'h0;
                advance = 1'b1;
            end else begin
                prescale_d = prescale_q + 3'h1;
            end
        end
        if (advance) begin
            count_d = count_q + 16'h0001; // RULE_11
            wrap = (count_q == 16'hffff); // RULE_11
        end
        if (trigger) begin
            count_d = `COUNT_RESET; // RULE_02
            wrap = 1'b0; // RULE_14
            prescale_d = 3'h0;
        end
        // software writes take precedence over the trigger
        if (wr_low) begin
            count_d[7:0] = pwdata[7:0]; // RULE_01
            if (wide_access_enable) begin
                count_d[15:8] = high_buffer_q; // RULE_12
            end
            prescale_d = 3'h0; // RULE_13
            wrap = 1'b0; // RULE_14
        end else if (wr_high && !wide_access_enable) begin
            count_d[15:8] = pwdata[7:0]; // RULE_01 RULE_14
            wrap = 1'b0;
        end
    end

    // count, prescaler and high buffer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= `COUNT_RESET;
            prescale_q <= 3'h0;
            high_buffer_q <= 8'h00;
        end else begin
            count_q <= count_d;
            prescale_q <= prescale_d;
            if (wr_high && wide_access_enable) begin
                high_buffer_q <= pwdata[7:0]; // RULE_13
            end else if (rd_low && wide_access_enable) begin
                high_buffer_q <= count_q[15:8]; // RULE_12
            end
        end
    end

    // ****************************************
    // control and flags registers
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= `CONTROL_RESET;
            overflow_flag_q <= 1'b0;
            overflow_irq_enable_q <= 1'b0;
        end else begin
            if (wr && paddr == `ADDR_CONTROL) begin
                control_q <= pwdata[7:0]; // RULE_03
            end
            if (wr && paddr == `ADDR_FLAGS) begin
                overflow_irq_enable_q <= pwdata[`BIT_OVERFLOW_IRQ_EN];
            end
            // set beats a software clear in the same cycle
            if (wrap) begin
                overflow_flag_q <= 1'b1; // RULE_11
            end else if (wr && paddr == `ADDR_FLAGS) begin
                overflow_flag_q <= pwdata[`BIT_OVERFLOW_FLAG];
            end
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always @* begin
        prdata = 32'h00000000;
        if (rd) begin
            case (paddr)
                `ADDR_CONTROL: prdata[7:0] = control_q;
                `ADDR_COUNT_LOW: prdata[7:0] = count_q[7:0]; // RULE_01
                `ADDR_COUNT_HIGH: prdata[7:0] = wide_access_enable ?
                    high_buffer_q : count_q[15:8]; // RULE_03 RULE_12
                `ADDR_FLAGS: begin
                    prdata[`BIT_OVERFLOW_FLAG] = overflow_flag_q;
                    prdata[`BIT_OVERFLOW_IRQ_EN] = overflow_irq_enable_q;
                end
                default: prdata = 32'h00000000;
            endcase
        end
    end
endmodule // sixteen_bit_timer_counter
`default_nettype wire

// >>> test/timer_counter_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks
// ****
module timer_counter_checker (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // count side
    input wire logic compare_lo_uses_this,
    input wire logic compare_hi_uses_this,
    input wire logic overflow_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase and accepted write
    wire acc = psel && penable;
    wire wr = acc && pwrite && pstrb[0];
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_unmap; acc && paddr > 12'h00c |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("no slverr");
    property p_idle; !acc |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("idle data");
    property p_byte; acc |-> prdata[31:8] == 24'h0; endproperty
    a_byte: assert property (p_byte) else $error("wide data");
    property p_hilo; compare_hi_uses_this |-> compare_lo_uses_this; endproperty
    a_hilo: assert property (p_hilo) else $error("select pair");
    property p_both;
        wr && paddr == 12'h000 && pwdata[6]
            |=> compare_hi_uses_this && compare_lo_uses_this;
    endproperty
    a_both: assert property (p_both) else $error("select both");
    property p_lo;
        wr && paddr == 12'h000 && !pwdata[6] && pwdata[3]
            |=> compare_lo_uses_this && !compare_hi_uses_this;
    endproperty
    a_lo: assert property (p_lo) else $error("select lo");
    property p_keep;
        !(wr && paddr == 12'h000) |=> $stable(compare_lo_uses_this);
    endproperty
    a_keep: assert property (p_keep) else $error("select moved");
    property p_irq; wr && paddr == 12'h00c && !pwdata[1] |=> !overflow_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq on");
endmodule // timer_counter_checker
bind sixteen_bit_timer_counter timer_counter_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_lo_uses_this(compare_lo_uses_this),
    .compare_hi_uses_this(compare_hi_uses_this),
    .overflow_irq(overflow_irq)
);
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_count_map.vh"
`define check(g, e) begin comparisons++; if ((g) !== (e)) begin \
    n_fail++; $display("ERROR %0t %h %h", $time, g, e); end end
// ****
// bench
// ****
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, q;
    logic [3:0] pstrb = 4'hf;
    logic pin = 0, t_lo = 0, t_hi = 0, pready, pslverr, s_lo, s_hi, irq;
    logic [7:0] h, l, e;
    int n_fail = 0, comparisons = 0, d;
    always #5 pclk = ~pclk;
    sixteen_bit_timer_counter dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_pin(pin), .compare_trigger_lo(t_lo),
        .compare_trigger_hi(t_hi), .compare_lo_uses_this(s_lo),
        .compare_hi_uses_this(s_hi), .overflow_irq(irq)
    );
    // verdict and end of run
    task finish_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one apb transfer, answer taken at the completing edge
    task apb(input logic w, input logic [11:0] a, input logic [7:0] v);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            finish_test();
        end
        r = prdata;
        q = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // five pulses on the external pin
    task pulses();
        repeat (5) begin
            pin <= 1'b1;
            repeat (3) @(posedge pclk);
            pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
    // running internal control word for a prescale code, sync bit set
    function logic [7:0] ctl(int p);
        return {2'b00, p[1:0], 4'b0101};
    endfunction
    initial begin
        void'($urandom(2));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 16; k += 4) begin
            apb(0, k[11:0], 0);
            `check(r, 32'h0)
        end
        apb(0, 12'h010, 0);
        `check(q, 32'h1)
        pstrb <= 4'h0;
        apb(1, `ADDR_CONTROL, 8'h40);
        pstrb <= 4'hf;
        apb(0, `ADDR_CONTROL, 0);
        `check(r, 32'h0)
        repeat (4) begin
            h = $urandom;
            apb(1, `ADDR_CONTROL, h);
            apb(0, `ADDR_CONTROL, 0);
            `check(r, {24'h0, h})
            `check(s_hi, h[6])
            `check(s_lo, h[6] | h[3])
        end
        h = $urandom;
        l = $urandom;
        apb(1, `ADDR_CONTROL, 8'h80);
        apb(1, `ADDR_COUNT_HIGH, h);
        apb(1, `ADDR_COUNT_LOW, l);
        apb(0, `ADDR_COUNT_LOW, 0);
        `check(r, {24'h0, l})
        apb(1, `ADDR_COUNT_HIGH, ~h);
        apb(1, `ADDR_CONTROL, 8'h00);
        apb(0, `ADDR_COUNT_HIGH, 0);
        `check(r, {24'h0, h})
        for (d = 0; d < 4; d++) begin
            apb(1, `ADDR_CONTROL, ctl(d));
            apb(0, `ADDR_COUNT_LOW, 0);
            e = r[7:0] + 8'd3;
            repeat ((12 << d) - 3) @(posedge pclk);
            apb(0, `ADDR_COUNT_LOW, 0);
            `check(r[7:0], e)
        end
        // wide mode, 1:8 internal: a low write restarts the prescaler,
        // a high buffer write leaves it running
        apb(1, `ADDR_CONTROL, 8'hb1);
        for (d = 0; d < 2; d++) begin
            apb(1, `ADDR_COUNT_LOW, 8'h00);
            repeat (16) @(posedge pclk);
            apb(1, d ? `ADDR_COUNT_HIGH : `ADDR_COUNT_LOW, 8'h00);
            repeat (16) @(posedge pclk);
            apb(0, `ADDR_COUNT_LOW, 0);
            `check(r, d ? 32'h1 : 32'h0)
        end
        apb(1, `ADDR_CONTROL, 8'h00);
        apb(0, `ADDR_COUNT_LOW, 0);
        e = r[7:0];
        repeat (20) @(posedge pclk);
        apb(0, `ADDR_COUNT_LOW, 0);
        `check(r[7:0], e)
        apb(1, `ADDR_COUNT_HIGH, 8'hff);
        apb(1, `ADDR_COUNT_LOW, 8'hff);
        apb(1, `ADDR_FLAGS, 8'h02);
        apb(1, `ADDR_CONTROL, 8'h01);
        repeat (12) @(posedge pclk);
        `check(irq, 1'b1)
        apb(0, `ADDR_FLAGS, 0);
        `check(r, 32'h3)
        apb(1, `ADDR_FLAGS, 8'h00);
        `check(irq, 1'b0)
        apb(1, `ADDR_CONTROL, 8'h40);
        apb(1, `ADDR_COUNT_HIGH, 8'h55);
        apb(1, `ADDR_COUNT_LOW, 8'h66);
        t_lo <= 1'b1;
        @(posedge pclk);
        t_lo <= 1'b0;
        @(posedge pclk);
        apb(0, `ADDR_COUNT_HIGH, 0);
        `check(r, 32'h0)
        apb(0, `ADDR_FLAGS, 0);
        `check(r, 32'h0)
        // trigger raised for the very access edge of a low byte write
        fork
            apb(1, `ADDR_COUNT_LOW, 8'h77);
            begin
                @(posedge pclk);
                t_lo <= 1'b1;
                @(posedge pclk);
                t_lo <= 1'b0;
            end
        join
        apb(0, `ADDR_COUNT_LOW, 0);
        `check(r, 32'h77)
        apb(1, `ADDR_CONTROL, 8'h08);
        apb(1, `ADDR_COUNT_LOW, 8'h10);
        t_hi <= 1'b1;
        @(posedge pclk);
        t_hi <= 1'b0;
        apb(1, `ADDR_CONTROL, 8'h07);
        pulses();
        apb(0, `ADDR_COUNT_LOW, 0);
        `check(r, 32'h14)
        // raw pin: a rise lands before the access edge of the read
        pin <= 1'b1;
        apb(0, `ADDR_COUNT_LOW, 0);
        `check(r, 32'h15)
        pin <= 1'b0;
        apb(1, `ADDR_CONTROL, 8'h03);
        pulses();
        apb(0, `ADDR_COUNT_LOW, 0);
        `check(r, 32'h1a)
        // synchronised pin: the same rise is still in the two stages
        pin <= 1'b1;
        apb(0, `ADDR_COUNT_LOW, 0);
        `check(r, 32'h1a)
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
